// >>> verilog/fsw_consts.svh
// constant definitions for the flash status and write control block
`ifndef FSW_CONSTS_SVH
`define FSW_CONSTS_SVH

// opcodes
`define FSW_OP_WREN        8'h06
`define FSW_OP_VWREN       8'h50
`define FSW_OP_WRDI        8'h04
`define FSW_OP_RDSTAT1     8'h05
`define FSW_OP_RDSTAT2     8'h35
`define FSW_OP_RDSTAT3     8'h15
`define FSW_OP_WRSTAT1     8'h01
`define FSW_OP_WRSTAT2     8'h31
`define FSW_OP_WRSTAT3     8'h11
`define FSW_OP_SET_RDPARAM 8'hC0
`define FSW_OP_PROG        8'h02
`define FSW_OP_QPROG       8'h32
`define FSW_OP_ERASE4K     8'h20
`define FSW_OP_ERASE32K    8'h52
`define FSW_OP_ERASE64K    8'hD8
`define FSW_OP_CHIP_ERASE1 8'hC7
`define FSW_OP_CHIP_ERASE2 8'h60
`define FSW_OP_RST_ENABLE  8'h66
`define FSW_OP_RST_DEVICE  8'h99
`define FSW_OP_DUAL_IO_RD  8'hBB
`define FSW_OP_QUAD_IO_RD  8'hEB

// status layout: bits 7:0 register one, 15:8 two, 23:16 three
`define FSW_BIT_BUSY       0
`define FSW_BIT_WRLATCH    1
`define FSW_WRITABLE_MASK  24'hE4_7BFC
`define FSW_OTP_MASK       24'h00_3900
`define FSW_QUAD_EN_MASK   24'h00_0200
`define FSW_STATUS_RST     24'h00_0000

// byte counts inside a frame, opcode included
`define FSW_NB_ONE_DATA    9'h002
`define FSW_NB_TWO_DATA    9'h003
`define FSW_NB_ADDR        9'h004
`define FSW_NB_ADDR_DATA   9'h005
`define FSW_IDX_MAX        9'h1FF

// read parameter byte fields
`define FSW_RDPARAM_RST    8'h00
`define FSW_DUMMY_LSB      4
`define FSW_WRAP_LSB       0
`define FSW_DUMMY_BASE     4'h2
`define FSW_WRAP_BASE      7'h08

// timing
`define FSW_CLK_PERIOD_NS  32'h0000_0008
`define FSW_MIN_CYCLES     32'h0000_0001
`endif

// >>> verilog/fsw_pkg.sv
// types shared by the flash status and write control block
package fsw_pkg;

  // one frame as captured at the link, held after chip select rises
  typedef struct packed {
    logic [7:0]  op;
    logic [23:0] addr;
    logic [7:0]  mode;
    logic [7:0]  d0;
    logic [7:0]  d1;
    logic [8:0]  nbytes;
    logic [7:0]  page_off;
  } fsw_frame_type;

  // status picture handed to the link while no frame is open
  typedef struct packed {
    logic [23:0] status;
    logic        qmode;
  } fsw_snap_type;

  typedef enum logic [1:0] {
    FSW_IDLE = 2'b01,
    FSW_BUSY = 2'b10
  } fsw_state_type;

  typedef enum logic [2:0] {
    FSW_JOB_WSTAT = 3'b001,
    FSW_JOB_PROG  = 3'b010,
    FSW_JOB_ERASE = 3'b100
  } fsw_job_type;

endpackage

// >>> verilog/fsw_status_ctrl.sv
// status register, write latch and frame decoding logic of a serial flash
`timescale 1ns/100ps
`default_nettype none
`include "fsw_consts.svh"

module fsw_status_ctrl #(
  parameter int unsigned STATUS_WRITE_NS = 32'h0098_9680,
  parameter int unsigned PAGE_PROG_NS    = 32'h002D_C6C0,
  parameter int unsigned ERASE_NS        = 32'h17D7_8400
) (
  input  wire logic        sys_clk_in,
  input  wire logic        rstn_in,
  input  wire logic        ce_in,
  input  wire logic        spi_clk_in,
  input  wire logic        cs_n_in,
  input  wire logic [3:0]  io_in,
  output logic      [3:0]  io_out_out,
  output logic      [3:0]  io_oe_out,
  input  wire logic        hw_reset_n_in,
  input  wire logic        four_lane_command_mode_in,
  output logic             busy_out,
  output logic             write_enable_latch_out,
  output logic      [23:0] status_out,
  output logic      [3:0]  dummy_clocks_out,
  output logic      [6:0]  wrap_bytes_out,
  output logic             prog_start_out,
  output logic             erase_start_out,
  output logic      [23:0] cmd_addr_out,
  output logic      [7:0]  page_offset_out,
  output logic      [7:0]  mode_bits_out
);

  localparam int unsigned WSTAT_CYC =
    ((STATUS_WRITE_NS / `FSW_CLK_PERIOD_NS) == 0) ? `FSW_MIN_CYCLES :
    STATUS_WRITE_NS / `FSW_CLK_PERIOD_NS;
  localparam int unsigned PROG_CYC =
    ((PAGE_PROG_NS / `FSW_CLK_PERIOD_NS) == 0) ? `FSW_MIN_CYCLES :
    PAGE_PROG_NS / `FSW_CLK_PERIOD_NS;
  localparam int unsigned ERASE_CYC =
    ((ERASE_NS / `FSW_CLK_PERIOD_NS) == 0) ? `FSW_MIN_CYCLES :
    ERASE_NS / `FSW_CLK_PERIOD_NS;

  // ---------------- link clock domain ----------------
  fsw_pkg::fsw_frame_type frm_r;
  fsw_pkg::fsw_snap_type  snap_r;
  logic [7:0]  sh_r;
  logic [3:0]  bitcnt_r;
  logic [8:0]  idx_r;
  logic        tog_r;
  logic [2:0]  lbusy_r;
  logic        lbusy_lvl_r;
  logic [2:0]  obit_r;
  logic [3:0]  io_out_r;
  logic [3:0]  io_oe_r;

  // frame-scoped counters clear while chip select is high
  wire         link_rstn = rstn_in & ~cs_n_in;
  wire         link_quad = snap_r.qmode;
  wire [7:0]   lop       = frm_r.op;
  wire         op_seen   = idx_r != 9'h000;
  wire         addr_ph   = op_seen && (idx_r <= `FSW_NB_ADDR);
  wire         dual_in   = !link_quad && addr_ph &&
                           (lop == `FSW_OP_DUAL_IO_RD);
  wire         quad_in   = link_quad ||
                           (addr_ph && lop == `FSW_OP_QUAD_IO_RD) ||
                           (op_seen && idx_r >= `FSW_NB_ADDR &&
                            lop == `FSW_OP_QPROG);
  wire [3:0]   in_w      = quad_in ? 4'h4 : (dual_in ? 4'h2 : 4'h1);
  // higher lane carries the higher bit; bits enter at the bottom
  wire [7:0]   sh_nxt    = quad_in ? {sh_r[3:0], io_in[3:0]} :
                           dual_in ? {sh_r[5:0], io_in[1:0]} :
                                     {sh_r[6:0], io_in[0]};
  wire [3:0]   bit_sum   = bitcnt_r + in_w;
  wire         byte_done = bit_sum == 4'h8;
  wire [8:0]   idx_nxt   = (idx_r == `FSW_IDX_MAX) ? idx_r : idx_r + 9'h001;

  always_ff @(posedge spi_clk_in or negedge link_rstn) begin
    if (!link_rstn) begin
      sh_r     <= 8'h00;
      bitcnt_r <= 4'h0;
      idx_r    <= 9'h000;
    end else begin
      sh_r     <= sh_nxt;
      bitcnt_r <= byte_done ? 4'h0 : bit_sum;
      if (byte_done) begin
        idx_r <= idx_nxt;
      end
    end
  end

  // captured frame survives chip select rising for the core to read
  always_ff @(posedge spi_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      frm_r <= '0;
      tog_r <= 1'b0;
    end else if (byte_done) begin
      frm_r.nbytes <= idx_nxt;
      if (idx_r == 9'h000) begin
        frm_r.op <= sh_nxt;
        tog_r    <= ~tog_r;
      end
      if (idx_r == 9'h001) begin
        frm_r.d0 <= sh_nxt;
      end
      if (idx_r == 9'h002) begin
        frm_r.d1 <= sh_nxt;
      end
      if (addr_ph && idx_r != `FSW_NB_ADDR) begin
        frm_r.addr <= {frm_r.addr[15:0], sh_nxt};
      end
      if (idx_r == `FSW_NB_ADDR) begin
        frm_r.mode <= sh_nxt;
      end
      if (idx_r == 9'h003) begin
        frm_r.page_off <= sh_nxt;
      end else if (idx_r >= `FSW_NB_ADDR) begin
        frm_r.page_off <= frm_r.page_off + 8'h01;
      end
    end
  end

  always_ff @(posedge spi_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      lbusy_r     <= 3'h0;
      lbusy_lvl_r <= 1'b0;
    end else begin
      lbusy_r <= {lbusy_r[1:0], status_out[`FSW_BIT_BUSY]};
      if (lbusy_r[1] == lbusy_r[2]) begin
        lbusy_lvl_r <= lbusy_r[2];
      end
    end
  end

  wire         rd_op     = lop == `FSW_OP_RDSTAT1 ||
                           lop == `FSW_OP_RDSTAT2 ||
                           lop == `FSW_OP_RDSTAT3;
  wire         rd_active = op_seen && rd_op;
  wire [7:0]   rd_byte   =
    (lop == `FSW_OP_RDSTAT2) ? snap_r.status[15:8] :
    (lop == `FSW_OP_RDSTAT3) ? snap_r.status[23:16] :
    {snap_r.status[7:1], lbusy_lvl_r};
  wire [7:0]   rd_rot    = rd_byte << obit_r;
  wire [2:0]   out_w     = link_quad ? 3'h4 : 3'h1;

  // status leaves on falling edges and wraps to repeat the same byte
  always_ff @(negedge spi_clk_in or negedge link_rstn) begin
    if (!link_rstn) begin
      obit_r   <= 3'h0;
      io_out_r <= 4'h0;
      io_oe_r  <= 4'h0;
    end else if (rd_active) begin
      obit_r   <= obit_r + out_w;
      io_oe_r  <= link_quad ? 4'hF : 4'h2;
      io_out_r <= link_quad ? rd_rot[7:4] :
                              {2'h0, rd_rot[7], 1'b0};
    end
  end

  assign io_out_out = io_out_r;
  assign io_oe_out  = io_oe_r;

  // ---------------- system clock domain ----------------
  logic [2:0]  s1_r, s2_r, s3_r, lvl_r, lvl_d_r;
  logic        seen_r;
  fsw_pkg::fsw_state_type state_r;
  fsw_pkg::fsw_job_type   job_r;
  logic [31:0] timer_r;
  logic [23:0] vol_r, nv_r, pend_r;
  logic        wel_r, vwe_r, arm_r;
  logic [7:0]  rdparam_r;
  logic [23:0] status_r;
  logic [3:0]  dummy_r;
  logic [6:0]  wrap_r;
  logic        prog_r, erase_r;
  logic [23:0] addr_r;
  logic [7:0]  off_r, mode_r;

  // bit 2 reset pin, bit 1 frame toggle, bit 0 chip select
  wire [2:0]   sync_in  = {hw_reset_n_in, tog_r, cs_n_in};
  wire [2:0]   lvl_nxt  = (s2_r & s3_r) | (lvl_r & (s2_r | s3_r));

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      s1_r    <= 3'h5;
      s2_r    <= 3'h5;
      s3_r    <= 3'h5;
      lvl_r   <= 3'h5;
      lvl_d_r <= 3'h5;
    end else if (ce_in) begin
      s1_r    <= sync_in;
      s2_r    <= s1_r;
      s3_r    <= s2_r;
      lvl_r   <= lvl_nxt;
      lvl_d_r <= lvl_r;
    end
  end

  wire         hw_rst    = ~lvl_r[2];
  wire         frame_end = lvl_r[0] & ~lvl_d_r[0];
  wire         exec      = frame_end & (lvl_r[1] != seen_r);
  wire         idle      = state_r == fsw_pkg::FSW_IDLE;
  wire         go        = exec & idle;
  wire [7:0]   op        = frm_r.op;
  wire [8:0]   nb        = frm_r.nbytes;
  wire         wstat_op  = op == `FSW_OP_WRSTAT1 ||
                           op == `FSW_OP_WRSTAT2 ||
                           op == `FSW_OP_WRSTAT3;
  wire         erase_op  = ((op == `FSW_OP_ERASE4K ||
                             op == `FSW_OP_ERASE32K ||
                             op == `FSW_OP_ERASE64K) &&
                            nb >= `FSW_NB_ADDR) ||
                           op == `FSW_OP_CHIP_ERASE1 ||
                           op == `FSW_OP_CHIP_ERASE2;
  wire         prog_op   = (op == `FSW_OP_PROG || op == `FSW_OP_QPROG) &&
                           nb >= `FSW_NB_ADDR_DATA;
  wire         read_io   = op == `FSW_OP_DUAL_IO_RD ||
                           op == `FSW_OP_QUAD_IO_RD;

  wire         cmd_wren  = go && op == `FSW_OP_WREN;
  wire         cmd_wrdi  = go && op == `FSW_OP_WRDI;
  wire         cmd_vwren = go && op == `FSW_OP_VWREN;
  wire         cmd_ws    = go && wstat_op && nb >= `FSW_NB_ONE_DATA;
  wire         ws_vol    = cmd_ws && vwe_r;
  wire         ws_nv     = cmd_ws && !vwe_r && wel_r;
  wire         cmd_prog  = go && prog_op && wel_r;
  wire         cmd_erase = go && erase_op && wel_r;
  wire         cmd_param = go && op == `FSW_OP_SET_RDPARAM &&
                           nb >= `FSW_NB_ONE_DATA;
  wire         cmd_rsten = go && op == `FSW_OP_RST_ENABLE;
  wire         cmd_swrst = go && op == `FSW_OP_RST_DEVICE && arm_r;
  wire         timer_end = !idle && timer_r == `FSW_MIN_CYCLES;

  // byte lanes touched by the write; 01h with two bytes covers two
  wire [2:0]   wr_en     =
    (op == `FSW_OP_WRSTAT2) ? 3'h2 :
    (op == `FSW_OP_WRSTAT3) ? 3'h4 :
    (nb >= `FSW_NB_TWO_DATA) ? 3'h3 : 3'h1;
  wire [23:0]  wr_data   =
    (op == `FSW_OP_WRSTAT2) ? {8'h00, frm_r.d0, 8'h00} :
    (op == `FSW_OP_WRSTAT3) ? {frm_r.d0, 16'h0000} :
                              {8'h00, frm_r.d1, frm_r.d0};
  wire [23:0]  lane_mask = {{8{wr_en[2]}}, {8{wr_en[1]}}, {8{wr_en[0]}}};
  wire [23:0]  qe_keep   = snap_r.qmode ? `FSW_QUAD_EN_MASK : 24'h00_0000;
  wire [23:0]  wr_mask   = `FSW_WRITABLE_MASK & lane_mask &
                           ~qe_keep;
  wire [23:0]  vol_new   = (vol_r & ~wr_mask) | (wr_data & wr_mask) |
                           (vol_r & `FSW_OTP_MASK);
  wire [23:0]  nv_new    = (nv_r & ~wr_mask) | (wr_data & wr_mask) |
                           (nv_r & `FSW_OTP_MASK);
  wire [23:0]  status_full = {vol_r[23:2], wel_r, !idle};
  wire [3:0]   dummy_nxt = {rdparam_r[`FSW_DUMMY_LSB+1 -: 2], 1'b0} +
                           `FSW_DUMMY_BASE;
  wire [6:0]   wrap_nxt  = `FSW_WRAP_BASE <<
                           rdparam_r[`FSW_WRAP_LSB+1 -: 2];

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      seen_r <= 1'b0;
      arm_r  <= 1'b0;
    end else if (ce_in) begin
      if (frame_end) begin
        seen_r <= lvl_r[1];
      end
      if (go) begin
        arm_r <= cmd_rsten;
      end
    end
  end

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state_r   <= fsw_pkg::FSW_IDLE;
      job_r     <= fsw_pkg::FSW_JOB_WSTAT;
      timer_r   <= 32'h0000_0000;
      vol_r     <= `FSW_STATUS_RST;
      nv_r      <= `FSW_STATUS_RST;
      pend_r    <= `FSW_STATUS_RST;
      wel_r     <= 1'b0;
      vwe_r     <= 1'b0;
      rdparam_r <= `FSW_RDPARAM_RST;
    end else if (ce_in) begin
      if (hw_rst || cmd_swrst) begin
        state_r   <= fsw_pkg::FSW_IDLE;
        vol_r     <= nv_r;
        wel_r     <= 1'b0;
        vwe_r     <= 1'b0;
        rdparam_r <= `FSW_RDPARAM_RST;
      end else begin
        if (timer_end) begin
          state_r <= fsw_pkg::FSW_IDLE;
          wel_r   <= 1'b0;
          if (job_r == fsw_pkg::FSW_JOB_WSTAT) begin
            nv_r  <= pend_r;
            vol_r <= pend_r;
          end
        end else if (!idle) begin
          timer_r <= timer_r - `FSW_MIN_CYCLES;
        end
        if (cmd_wren) begin
          wel_r <= 1'b1;
        end
        if (cmd_wrdi) begin
          wel_r <= 1'b0;
        end
        if (cmd_vwren) begin
          vwe_r <= 1'b1;
        end
        if (go && wstat_op) begin
          vwe_r <= 1'b0;
        end
        if (ws_vol) begin
          vol_r <= vol_new;
        end
        if (ws_nv) begin
          pend_r  <= nv_new;
          job_r   <= fsw_pkg::FSW_JOB_WSTAT;
          timer_r <= WSTAT_CYC;
          state_r <= fsw_pkg::FSW_BUSY;
        end
        if (cmd_prog) begin
          job_r   <= fsw_pkg::FSW_JOB_PROG;
          timer_r <= PROG_CYC;
          state_r <= fsw_pkg::FSW_BUSY;
        end
        if (cmd_erase) begin
          job_r   <= fsw_pkg::FSW_JOB_ERASE;
          timer_r <= ERASE_CYC;
          state_r <= fsw_pkg::FSW_BUSY;
        end
        if (cmd_param) begin
          rdparam_r <= frm_r.d0;
        end
      end
    end
  end

  // registered outputs and the picture handed to the link
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      status_r <= `FSW_STATUS_RST;
      snap_r   <= '0;
      dummy_r  <= `FSW_DUMMY_BASE;
      wrap_r   <= `FSW_WRAP_BASE;
      prog_r   <= 1'b0;
      erase_r  <= 1'b0;
      addr_r   <= 24'h00_0000;
      off_r    <= 8'h00;
      mode_r   <= 8'h00;
    end else if (ce_in) begin
      status_r <= status_full;
      if (lvl_r[0]) begin
        snap_r.status <= status_full;
        snap_r.qmode  <= four_lane_command_mode_in;
      end
      dummy_r <= dummy_nxt;
      wrap_r  <= wrap_nxt;
      prog_r  <= cmd_prog;
      erase_r <= cmd_erase;
      if (cmd_prog || cmd_erase || (go && read_io)) begin
        addr_r <= frm_r.addr;
      end
      if (cmd_prog) begin
        off_r <= frm_r.page_off;
      end
      if (go && read_io && nb > `FSW_NB_ADDR) begin
        mode_r <= frm_r.mode;
      end
    end
  end

  assign busy_out               = status_r[`FSW_BIT_BUSY];
  assign write_enable_latch_out = status_r[`FSW_BIT_WRLATCH];
  assign status_out             = status_r;
  assign dummy_clocks_out       = dummy_r;
  assign wrap_bytes_out         = wrap_r;
  assign prog_start_out         = prog_r;
  assign erase_start_out        = erase_r;
  assign cmd_addr_out           = addr_r;
  assign page_offset_out        = off_r;
  assign mode_bits_out          = mode_r;

endmodule
`default_nettype wire

// >>> verif/fsw_status_ctrl_chk.sv
// port-level assertions for the flash status and write control block
`timescale 1ns/100ps
`default_nettype none
module fsw_status_ctrl_chk #(
  parameter int unsigned STATUS_WRITE_NS = 32'h0000_0190,
  parameter int unsigned PAGE_PROG_NS    = 32'h0000_0190,
  parameter int unsigned ERASE_NS        = 32'h0000_0320
) (
  input wire logic        sys_clk_in,
  input wire logic        rstn_in,
  input wire logic        cs_n_in,
  input wire logic        hw_reset_n_in,
  input wire logic [3:0]  io_oe_out,
  input wire logic        busy_out,
  input wire logic        write_enable_latch_out,
  input wire logic [23:0] status_out,
  input wire logic [3:0]  dummy_clocks_out,
  input wire logic [6:0]  wrap_bytes_out,
  input wire logic        prog_start_out,
  input wire logic        erase_start_out
);
  localparam int BMAX = (STATUS_WRITE_NS + PAGE_PROG_NS + ERASE_NS) / 8 + 20;
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rstn_in);
  AST_BUSY_BIT: assert property (status_out[0] == busy_out)
    else $error("busy bit and busy port differ");
  AST_LATCH_BIT: assert property (status_out[1] == write_enable_latch_out)
    else $error("latch bit and latch port differ");
  AST_LATCH_AFTER_BUSY: assert property ($fell(busy_out) |-> !write_enable_latch_out)
    else $error("latch still set after busy ended");
  AST_BUSY_SPAN: assert property ($rose(busy_out) |-> busy_out[*8] ##[1:BMAX] !busy_out)
    else $error("busy cycle too short or too long");
  AST_PROG_LATCH: assert property (prog_start_out |-> write_enable_latch_out || $past(write_enable_latch_out))
    else $error("program started without latch");
  AST_ERASE_LATCH: assert property (erase_start_out |-> write_enable_latch_out || $past(write_enable_latch_out))
    else $error("erase started without latch");
  AST_START_BUSY: assert property ((prog_start_out || erase_start_out) |=> !prog_start_out && !erase_start_out ##[0:3] busy_out)
    else $error("start pulse not followed by busy");
  AST_DUMMY_SET: assert property (dummy_clocks_out inside {4'h2, 4'h4, 4'h6, 4'h8})
    else $error("dummy clock count out of set");
  AST_WRAP_SET: assert property (wrap_bytes_out inside {7'h08, 7'h10, 7'h20, 7'h40})
    else $error("wrap length out of set");
  AST_OTP_KEEP: assert property (hw_reset_n_in && $past(hw_reset_n_in, 6) |-> ($past(status_out) & ~status_out & 24'h00_3900) == 24'h00_0000)
    else $error("lock bit returned to zero");
  AST_IDLE_LANES: assert property (cs_n_in |-> io_oe_out == 4'h0)
    else $error("lanes driven without chip select");
  cover property (prog_start_out);
  cover property (erase_start_out);
  cover property ($fell(busy_out));
endmodule
`default_nettype wire

// >>> verif/fsw_host_model.sv
// host controller model: frames bytes onto the link and samples read data
`timescale 1ns/100ps
`default_nettype none
module fsw_host_model (
  output logic            spi_clk_out,
  output logic            cs_n_out,
  output logic      [3:0] lane_out,
  input  wire logic [3:0] lane_in
);
  initial begin
    spi_clk_out = 1'b0;
    cs_n_out = 1'b1;
    lane_out = 4'h5;
  end
  // drive in the low phase, sample on the rise; clock stands still between
  task automatic bit_time(input logic b, output logic s);
    lane_out = {~lane_out[3:1], b};
    #24 spi_clk_out = 1'b1;
    s = lane_in[1];
    #24 spi_clk_out = 1'b0;
  endtask
  task automatic xfer(input logic [7:0] q[$], input int nrd, output logic [15:0] rd);
    logic s;
    rd = 16'h0000;
    #3 cs_n_out = 1'b0;
    foreach (q[i]) begin
      for (int k = 7; k >= 0; k--) bit_time(q[i][k], s);
    end
    for (int k = 0; k < 8 * nrd; k++) begin
      bit_time(~lane_out[0], s);
      rd = {rd[14:0], s};
    end
    #24 cs_n_out = 1'b1;
    lane_out = ~lane_out; // released lanes show the inverse
    #117;
  endtask
endmodule
`default_nettype wire

// >>> verif/testbench.sv
// self-checking bench for the flash status and write control block
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic        sys_clk_in;
  logic        rstn_in;
  logic        ce_in;
  logic        hw_reset_n_in;
  logic        spi_clk_in;
  logic        cs_n_in;
  logic [3:0]  host_lane;
  logic [3:0]  io_out_out;
  logic [3:0]  io_oe_out;
  logic        busy_out;
  logic        write_enable_latch_out;
  logic [23:0] status_out;
  logic [3:0]  dummy_clocks_out;
  logic [6:0]  wrap_bytes_out;
  logic        prog_start_out;
  logic        erase_start_out;
  logic [23:0] cmd_addr_out;
  logic [7:0]  page_offset_out;
  logic [15:0] rd;
  int          fails;
  int          total_checks;
  int          cycles;
  wire  [3:0]  io_in = (io_oe_out & io_out_out) | (~io_oe_out & host_lane);
  fsw_status_ctrl #(.STATUS_WRITE_NS(2400), .PAGE_PROG_NS(800), .ERASE_NS(1600)) u_dut (
    .sys_clk_in, .rstn_in, .ce_in, .spi_clk_in, .cs_n_in, .io_in,
    .io_out_out, .io_oe_out, .hw_reset_n_in, .four_lane_command_mode_in(1'b0),
    .busy_out, .write_enable_latch_out, .status_out, .dummy_clocks_out,
    .wrap_bytes_out, .prog_start_out, .erase_start_out, .cmd_addr_out,
    .page_offset_out, .mode_bits_out());
  fsw_host_model u_host (.spi_clk_out(spi_clk_in), .cs_n_out(cs_n_in),
    .lane_out(host_lane), .lane_in(io_in));
  initial begin
    sys_clk_in = 1'b0;
    forever #4 sys_clk_in = ~sys_clk_in;
  end
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic send(input logic [7:0] q[$]);
    u_host.xfer(q, 0, rd);
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    while (busy_out !== 1'b0 && n < 1000) begin
      @(negedge sys_clk_in);
      n++;
    end
    chk({23'h0, busy_out}, 24'h00_0000);
    repeat (8) @(negedge sys_clk_in);
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  always @(posedge sys_clk_in) begin
    cycles++;
    if (cycles == 30000) begin
      fails++;
      stop_test();
    end
  end
  initial begin
    rstn_in = 1'b0;
    ce_in = 1'b1;
    hw_reset_n_in = 1'b1;
    repeat (20) @(negedge sys_clk_in);
    rstn_in = 1'b1;
    repeat (6) @(negedge sys_clk_in);
    chk(status_out, 24'h00_0000);
    chk({dummy_clocks_out, 13'h0, wrap_bytes_out}, 24'h20_0008);
    send('{8'h01, 8'hFF});
    chk(status_out, 24'h00_0000);
    send('{8'h06});
    chk({23'h0, write_enable_latch_out}, 24'h00_0001);
    send('{8'h04});
    chk({23'h0, write_enable_latch_out}, 24'h00_0000);
    send('{8'h06});
    send('{8'h01, 8'hFF});
    u_host.xfer('{8'h05}, 2, rd);
    chk({8'h0, rd}, 24'h00_0303);
    wait_idle();
    chk(status_out, 24'h00_00FC);
    send('{8'h50});
    chk({23'h0, write_enable_latch_out}, 24'h00_0000);
    send('{8'h11, 8'hFF});
    chk(status_out, 24'hE4_00FC);
    send('{8'h50});
    send('{8'h01, 8'h00, 8'h39});
    chk(status_out, 24'hE4_3900);
    send('{8'h50});
    send('{8'h31, 8'h00});
    chk(status_out, 24'hE4_3900);
    u_host.xfer('{8'h35}, 2, rd);
    chk({8'h0, rd}, 24'h00_3939);
    send('{8'h06});
    send('{8'h02, 8'h00, 8'h01, 8'hFF, 8'hAA, 8'hBB});
    chk(cmd_addr_out, 24'h00_01FF);
    chk({16'h0, page_offset_out}, 24'h00_0001);
    wait_idle();
    chk({23'h0, write_enable_latch_out}, 24'h00_0000);
    send('{8'h02, 8'h00, 8'h00, 8'h10, 8'hAA});
    chk({busy_out, cmd_addr_out[22:0]}, 24'h00_01FF);
    send('{8'h06});
    send('{8'h20, 8'h01, 8'h20, 8'h00});
    chk(cmd_addr_out, 24'h01_2000);
    wait_idle();
    chk({23'h0, write_enable_latch_out}, 24'h00_0000);
    for (int k = 0; k < 4; k++) begin
      send('{8'hC0, {2'b00, k[1:0], 2'b00, k[1:0]}});
      chk({dummy_clocks_out, wrap_bytes_out}, {4'(2 * k + 2), 7'(8 << k)});
    end
    // frozen core misses a whole frame; only the reset pin follows
    ce_in = 1'b0;
    send('{8'h06});
    chk({23'h0, write_enable_latch_out}, 24'h00_0000);
    @(negedge sys_clk_in);
    ce_in = 1'b1;
    hw_reset_n_in = 1'b0;
    repeat (10) @(negedge sys_clk_in);
    hw_reset_n_in = 1'b1;
    repeat (10) @(negedge sys_clk_in);
    chk({8'h0, status_out[23:16], status_out[7:0]}, 24'h00_00FC);
    chk({dummy_clocks_out, 13'h0, wrap_bytes_out}, 24'h20_0008);
    stop_test();
  end
endmodule
bind fsw_status_ctrl fsw_status_ctrl_chk #(.STATUS_WRITE_NS(STATUS_WRITE_NS),
  .PAGE_PROG_NS(PAGE_PROG_NS), .ERASE_NS(ERASE_NS)) u_chk (
  .sys_clk_in, .rstn_in, .cs_n_in, .hw_reset_n_in, .io_oe_out, .busy_out,
  .write_enable_latch_out, .status_out, .dummy_clocks_out, .wrap_bytes_out,
  .prog_start_out, .erase_start_out);
`default_nettype wire
